//--- mpc_checker.sv
/*
 * Region attribute store, region match and permission checker.
 * Holds eight regions behind a plain register port and checks each core
 * access presented on ACC; the verdict appears one cycle after the request.
 * Assumes one core clock, synchronous inputs and a master that never
 * raises read and write strobes together.
 */
//
// Summary of operation
// - Attribute fields decide each region's access control
// - Denied access faults and is not completed
// - Code 000 denies every access
// - 001 privileged only; 011 full access
// - 010 lets unprivileged read, not write
// - 101 privileged read only, writes fault
// - 110 and 111 read only; 100 reserved
// - Ignore shareable bit where marked don't-care
// - Type 000 cacheable is write-through normal
// - Type 001 C and B is write-back
// - Top type bit gives normal memory, outer policy from type bits, inner from C and B
// - Two-bit policy codes decode per table
// - Policy attributes never alter access behaviour
// - Violation raises a memory management fault
// - Violation cause recorded in fault status
// - Highest numbered matching region wins
// - Background region for privileged accesses only
// - Disabled subregion excluded, faults if uncovered
`timescale 1ns/1ps
module mpc_checker #(
   parameter int NREG = 8                        // number of regions
) (
   input  wire logic                   CLK,         // core clock, 25 MHz
   input  wire logic                   RSTN,        // async reset, active low
   input  wire logic [7:0]             REG_ADDR,    // register byte address
   input  wire logic [31:0]            REG_WDATA,   // register write data
   input  wire logic                   REG_WR,      // write strobe
   input  wire logic                   REG_RD,      // read strobe
   output logic [31:0]                 REG_RDATA,   // read data, cycle after strobe
   input  wire mpc_pkg::mpc_access_s   ACC,         // access request from core
   output logic                        ACC_DONE,    // verdict pulse
   output logic                        ACC_FAULT,   // access denied pulse
   output mpc_pkg::mpc_mem_attr_s      ACC_ATTR,    // attributes of the access
   output logic                        MM_FAULT     // fault exception request pulse
);

   localparam int RW = $clog2(NREG);

   // Region table, fault state and outputs
   typedef struct packed {
      logic                                      ctrl_en;
      logic                                      ctrl_bgen;
      logic [RW-1:0]                             number;
      logic [NREG-1:0][26:0]                     base;
      mpc_pkg::mpc_region_attr_s [NREG-1:0]      attr;
      logic                                      fsr_iacc;
      logic                                      fsr_dacc;
      logic                                      fsr_avalid;
      logic [31:0]                               faddr;
      logic [31:0]                               rdata;
      logic                                      done;
      logic                                      fault;
      logic                                      mm;
      mpc_pkg::mpc_mem_attr_s                    acc_attr;
   } mpc_state_s;

   mpc_state_s st_reg;
   mpc_state_s st_next;

   // Region window compare: size code n spans 2^(n+1) bytes
   function automatic logic in_window(input logic [31:0] a,
                                      input logic [26:0] base,
                                      input logic [4:0]  size);
      logic [31:0] mask;
      logic [5:0]  span;

      // Six bits, so size 31 clears the whole mask
      span = {1'b0, size} + 6'h01;
      mask = 32'hFFFF_FFFF << span;
      if (size < mpc_pkg::SIZE_MIN) begin
         mask = 32'hFFFF_FFE0;
      end
      return ((a ^ {base, 5'h00}) & mask) == 32'h0000_0000;
   endfunction

   // Which eighth of the region the address falls in
   function automatic logic [2:0] sub_index(input logic [31:0] a,
                                            input logic [4:0]  size);
      logic [31:0] sh;

      // Valid from 256 bytes up; caller masks the rest
      sh = a >> (size - 5'h02);
      return sh[2:0];
   endfunction

   function automatic logic [31:0] pack_attr(input mpc_pkg::mpc_region_attr_s r);
      logic [31:0] w;

      // Unused bits read as zero
      w = 32'h0000_0000;
      w[mpc_pkg::ATTR_EN_BIT]                        = r.en;
      w[mpc_pkg::ATTR_SIZE_LSB +: 5]                 = r.size;
      w[mpc_pkg::ATTR_SRD_LSB +: 8]                  = r.subregion_disable_field;
      w[mpc_pkg::ATTR_B_BIT]                         = r.b;
      w[mpc_pkg::ATTR_C_BIT]                         = r.c;
      w[mpc_pkg::ATTR_S_BIT]                         = r.s;
      w[mpc_pkg::ATTR_TEX_LSB +: 3]                  = r.type_extension_field;
      w[mpc_pkg::ATTR_AP_LSB +: 3]                   = r.ap;
      w[mpc_pkg::ATTR_XN_BIT]                        = r.xn;
      return w;
   endfunction

   function automatic mpc_pkg::mpc_region_attr_s unpack_attr(input logic [31:0] w);
      mpc_pkg::mpc_region_attr_s r;

      r.en   = w[mpc_pkg::ATTR_EN_BIT];
      r.size = w[mpc_pkg::ATTR_SIZE_LSB +: 5];
      r.subregion_disable_field  = w[mpc_pkg::ATTR_SRD_LSB +: 8];
      r.b    = w[mpc_pkg::ATTR_B_BIT];
      r.c    = w[mpc_pkg::ATTR_C_BIT];
      r.s    = w[mpc_pkg::ATTR_S_BIT];
      r.type_extension_field  = w[mpc_pkg::ATTR_TEX_LSB +: 3];
      r.ap   = w[mpc_pkg::ATTR_AP_LSB +: 3];
      r.xn   = w[mpc_pkg::ATTR_XN_BIT];
      return r;
   endfunction

   // Per-region hit, subregions carved out
   logic [NREG-1:0] hit;

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++) begin : g_hit
         logic sub_off;
         always_comb begin
            sub_off = (st_reg.attr[gi].size >= mpc_pkg::SIZE_SUBREGION_MIN) &&
                      st_reg.attr[gi].subregion_disable_field[sub_index(ACC.addr, st_reg.attr[gi].size)];
            hit[gi] = st_reg.attr[gi].en && !sub_off &&
                      in_window(ACC.addr, st_reg.base[gi], st_reg.attr[gi].size);
         end
      end
   endgenerate

   // Highest numbered hit wins
   logic                      any_hit;
   mpc_pkg::mpc_region_attr_s sel;

   always_comb begin
      any_hit = 1'b0;
      sel     = '0;
      for (int i = 0; i < NREG; i++) begin
         // Later index overwrites, top match stays
         if (hit[i]) begin
            any_hit = 1'b1;
            sel     = st_reg.attr[i];
         end
      end
   end

   mpc_pkg::mpc_mem_attr_s dec_attr;
   logic                   perm_ok;

   // Type decode of the winning region
   mpc_type_decode u_decode (
      .type_extension_field  (sel.type_extension_field),
      .s    (sel.s),
      .c    (sel.c),
      .b    (sel.b),
      .attr (dec_attr)
   );

   // Privilege and direction against the winner
   mpc_perm_check u_perm (
      .ap      (sel.ap),
      .xn      (sel.xn),
      .priv    (ACC.priv),
      .write   (ACC.write),
      .fetch   (ACC.fetch),
      .allowed (perm_ok)
   );

   // Overall verdict and attributes of the current access
   logic                   grant;
   mpc_pkg::mpc_mem_attr_s eff_attr;

   always_comb begin
      if (!st_reg.ctrl_en) begin
         // Unit off: nothing checked, default map
         grant    = 1'b1;
         eff_attr = mpc_pkg::DEFAULT_ATTR;
      end else if (any_hit) begin
         grant    = perm_ok;
         eff_attr = dec_attr;
      end else begin
         // Uncovered address, including an excluded subregion
         grant    = ACC.priv && st_reg.ctrl_bgen;
         eff_attr = mpc_pkg::DEFAULT_ATTR;
      end
   end

   // Write strobe aimed at one offset
   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] o);
      return wr && (a == o);
   endfunction

   logic        wr_ctrl;
   logic        wr_num;
   logic        wr_base;
   logic        wr_attr;
   logic        wr_fsr;
   logic        wr_faddr;
   logic        viol;
   logic [31:0] rd_word;

   always_comb begin
      st_next = st_reg;

      wr_ctrl  = wr_hit(REG_WR, REG_ADDR, mpc_pkg::OFS_CTRL);
      wr_num   = wr_hit(REG_WR, REG_ADDR, mpc_pkg::OFS_NUMBER);
      wr_base  = wr_hit(REG_WR, REG_ADDR, mpc_pkg::OFS_BASE);
      wr_attr  = wr_hit(REG_WR, REG_ADDR, mpc_pkg::OFS_ATTR);
      wr_fsr   = wr_hit(REG_WR, REG_ADDR, mpc_pkg::OFS_FSR);
      wr_faddr = wr_hit(REG_WR, REG_ADDR, mpc_pkg::OFS_FADDR);

      if (wr_ctrl) begin
         st_next.ctrl_en   = REG_WDATA[mpc_pkg::CTRL_ENABLE_BIT];
         st_next.ctrl_bgen = REG_WDATA[mpc_pkg::CTRL_BGEN_BIT];
      end

      if (wr_num) begin
         st_next.number = REG_WDATA[RW-1:0];
      end

      if (wr_base) begin
         // Valid bit lets one write retarget the region number too
         if (REG_WDATA[mpc_pkg::BASE_VALID_BIT]) begin
            st_next.number = REG_WDATA[RW-1:0];
            st_next.base[REG_WDATA[RW-1:0]] = REG_WDATA[31:mpc_pkg::BASE_ADDR_LSB];
         end else begin
            st_next.base[st_reg.number] = REG_WDATA[31:mpc_pkg::BASE_ADDR_LSB];
         end
      end

      // Lands on the selected region only
      if (wr_attr) begin
         st_next.attr[st_reg.number] = unpack_attr(REG_WDATA);
      end

      if (wr_faddr) begin
         st_next.faddr = REG_WDATA;
      end

      // Access verdict, one cycle after the request
      // Uses st_reg, so same-edge writes act later
      viol = ACC.valid && !grant;
      st_next.done  = ACC.valid;
      st_next.fault = viol;
      st_next.mm    = viol;
      // Only type matters downstream; policy is reported, never acted on
      if (ACC.valid) begin
         st_next.acc_attr = eff_attr;
      end

      // Fault status: write one to clear, a new fault beats the clear
      if (wr_fsr) begin
         if (REG_WDATA[mpc_pkg::FSR_IACC_BIT]) begin
            st_next.fsr_iacc = 1'b0;
         end
         if (REG_WDATA[mpc_pkg::FSR_DACC_BIT]) begin
            st_next.fsr_dacc = 1'b0;
         end
         if (REG_WDATA[mpc_pkg::FSR_AVALID_BIT]) begin
            st_next.fsr_avalid = 1'b0;
         end
      end

      // Fetch and data faults kept apart
      if (viol && ACC.fetch) begin
         st_next.fsr_iacc = 1'b1;
      end
      if (viol && !ACC.fetch) begin
         st_next.fsr_dacc = 1'b1;
         // First data fault address is kept until software frees it
         if (!st_next.fsr_avalid) begin
            st_next.fsr_avalid = 1'b1;
            st_next.faddr      = ACC.addr;
         end
      end

      // Read data stands only in the cycle after the strobe
      rd_word = 32'h0000_0000;
      if (REG_RD) begin
         case (REG_ADDR)
            mpc_pkg::OFS_CTRL: begin
               rd_word[mpc_pkg::CTRL_ENABLE_BIT] = st_reg.ctrl_en;
               rd_word[mpc_pkg::CTRL_BGEN_BIT]   = st_reg.ctrl_bgen;
            end
            mpc_pkg::OFS_NUMBER: begin
               rd_word[RW-1:0] = st_reg.number;
            end
            mpc_pkg::OFS_BASE: begin
               rd_word[31:mpc_pkg::BASE_ADDR_LSB] = st_reg.base[st_reg.number];
               rd_word[RW-1:0]                    = st_reg.number;
            end
            mpc_pkg::OFS_ATTR: begin
               rd_word = pack_attr(st_reg.attr[st_reg.number]);
            end
            mpc_pkg::OFS_FSR: begin
               rd_word[mpc_pkg::FSR_IACC_BIT]   = st_reg.fsr_iacc;
               rd_word[mpc_pkg::FSR_DACC_BIT]   = st_reg.fsr_dacc;
               rd_word[mpc_pkg::FSR_AVALID_BIT] = st_reg.fsr_avalid;
            end
            mpc_pkg::OFS_FADDR: begin
               rd_word = st_reg.faddr;
            end
            default: begin
               rd_word = 32'h0000_0000;
            end
         endcase
      end
      st_next.rdata = rd_word;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         // Unit off, every region disabled
         st_reg          <= '0;
         st_reg.number   <= '0;
         st_reg.faddr    <= mpc_pkg::RST_WORD;
         st_reg.rdata    <= mpc_pkg::RST_WORD;
         st_reg.acc_attr <= mpc_pkg::DEFAULT_ATTR;
      end else begin
         st_reg <= st_next;
      end
   end

   // Every output straight from st_reg
   assign REG_RDATA = st_reg.rdata;
   assign ACC_DONE  = st_reg.done;
   assign ACC_FAULT = st_reg.fault;
   assign ACC_ATTR  = st_reg.acc_attr;
   assign MM_FAULT  = st_reg.mm;

endmodule

//--- mpc_pkg.sv
/*
 * Shared constants and types for the region attribute and permission checker.
 * Assumes a single core clock; all users refer to items as mpc_pkg::name.
 */
package mpc_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_NUMBER = 8'h04;
   localparam logic [7:0] OFS_BASE   = 8'h08;
   localparam logic [7:0] OFS_ATTR   = 8'h0C;
   localparam logic [7:0] OFS_FSR    = 8'h10;
   localparam logic [7:0] OFS_FADDR  = 8'h14;

   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_BGEN_BIT   = 2;

   // Base register fields
   localparam int BASE_VALID_BIT = 4;
   localparam int BASE_ADDR_LSB  = 5;

   // Attribute and size register fields
   localparam int ATTR_EN_BIT   = 0;
   localparam int ATTR_SIZE_LSB = 1;
   localparam int ATTR_SRD_LSB  = 8;
   localparam int ATTR_B_BIT    = 16;
   localparam int ATTR_C_BIT    = 17;
   localparam int ATTR_S_BIT    = 18;
   localparam int ATTR_TEX_LSB  = 19;
   localparam int ATTR_AP_LSB   = 24;
   localparam int ATTR_XN_BIT   = 28;

   // Fault status fields
   localparam int FSR_IACC_BIT  = 0;
   localparam int FSR_DACC_BIT  = 1;
   localparam int FSR_AVALID_BIT = 7;

   // Smallest size code that carries subregions (256 bytes)
   localparam logic [4:0] SIZE_SUBREGION_MIN = 5'h07;
   // Smallest legal size code (32 bytes)
   localparam logic [4:0] SIZE_MIN = 5'h04;

   // Reset values
   localparam logic [31:0] RST_WORD  = 32'h0000_0000;
   localparam logic [2:0]  RST_NUM   = 3'h0;

   // Access permission codes
   localparam logic [2:0] AP_NONE      = 3'h0;
   localparam logic [2:0] AP_PRIV_RW   = 3'h1;
   localparam logic [2:0] AP_USER_RO   = 3'h2;
   localparam logic [2:0] AP_FULL      = 3'h3;
   localparam logic [2:0] AP_RESERVED  = 3'h4;
   localparam logic [2:0] AP_PRIV_RO   = 3'h5;
   localparam logic [2:0] AP_RO_A      = 3'h6;
   localparam logic [2:0] AP_RO_B      = 3'h7;

   // Cache policy codes
   localparam logic [1:0] POL_NONCACHE  = 2'h0;
   localparam logic [1:0] POL_WB_RWA    = 2'h1;
   localparam logic [1:0] POL_WT_NOWA   = 2'h2;
   localparam logic [1:0] POL_WB_NOWA   = 2'h3;

   typedef enum logic [1:0] {
      MEM_STRONG = 2'h0,
      MEM_DEVICE = 2'h1,
      MEM_NORMAL = 2'h2
   } mpc_mem_type_e;

   typedef struct packed {
      logic       xn;
      logic [2:0] ap;
      logic [2:0] type_extension_field;
      logic       s;
      logic       c;
      logic       b;
      logic [7:0] subregion_disable_field;
      logic [4:0] size;
      logic       en;
   } mpc_region_attr_s;

   typedef struct packed {
      mpc_mem_type_e mtype;
      logic          shareable;
      logic [1:0]    inner;
      logic [1:0]    outer;
      logic          reserved;
   } mpc_mem_attr_s;

   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
      logic        write;
      logic        priv;
      logic        fetch;
   } mpc_access_s;

   // Attributes used for the background region and a disabled unit
   localparam mpc_mem_attr_s DEFAULT_ATTR = '{MEM_NORMAL, 1'b0, POL_WT_NOWA, POL_WT_NOWA, 1'b0};

endpackage

//--- mpc_type_decode.sv
/*
 * Memory type and cache policy decode of one region's attribute fields.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ps
module mpc_type_decode (
   input  wire logic [2:0]            type_extension_field,   // type extension
   input  wire logic                  s,     // shareable bit
   input  wire logic                  c,     // cacheable bit
   input  wire logic                  b,     // bufferable bit
   output mpc_pkg::mpc_mem_attr_s     attr   // decoded type and policy
);

   always_comb begin
      // Reserved encodings fall back to strongly ordered, no caching
      attr = '{mpc_pkg::MEM_STRONG, 1'b1, mpc_pkg::POL_NONCACHE,
               mpc_pkg::POL_NONCACHE, 1'b1};
      if (type_extension_field[2]) begin
         attr.mtype     = mpc_pkg::MEM_NORMAL;
         attr.shareable = s;
         attr.outer     = type_extension_field[1:0];
         attr.inner     = {c, b};
         attr.reserved  = 1'b0;
      end else begin
         case (type_extension_field[1:0])
            2'h0: begin
               attr.reserved = 1'b0;
               if (!c) begin
                  // Shareable bit ignored here
                  attr.mtype     = b ? mpc_pkg::MEM_DEVICE : mpc_pkg::MEM_STRONG;
                  attr.shareable = 1'b1;
               end else begin
                  attr.mtype     = mpc_pkg::MEM_NORMAL;
                  attr.shareable = s;
                  attr.inner     = mpc_pkg::POL_WT_NOWA;
                  attr.outer     = mpc_pkg::POL_WT_NOWA;
               end
            end
            2'h1: begin
               if (c == b) begin
                  attr.mtype     = mpc_pkg::MEM_NORMAL;
                  attr.shareable = s;
                  attr.reserved  = 1'b0;
                  attr.inner     = c ? mpc_pkg::POL_WB_RWA : mpc_pkg::POL_NONCACHE;
                  attr.outer     = c ? mpc_pkg::POL_WB_RWA : mpc_pkg::POL_NONCACHE;
               end
            end
            2'h2: begin
               if (!c && !b) begin
                  attr.mtype     = mpc_pkg::MEM_DEVICE;
                  attr.shareable = 1'b0;
                  attr.reserved  = 1'b0;
               end
            end
            default: begin
               attr.reserved = 1'b1;
            end
         endcase
      end
   end

endmodule

//--- mpc_perm_check.sv
/*
 * Access permission check of one access against one permission code.
 * Purely combinational; reserved code 100 is treated as no access.
 */
`timescale 1ns/1ps
module mpc_perm_check (
   input  wire logic [2:0] ap,       // access permission code
   input  wire logic       xn,       // execute never
   input  wire logic       priv,     // privileged access
   input  wire logic       write,    // write access
   input  wire logic       fetch,    // instruction fetch
   output logic            allowed   // access granted
);

   logic rd_ok;
   logic wr_ok;

   always_comb begin
      rd_ok = 1'b0;
      wr_ok = 1'b0;
      case (ap)
         mpc_pkg::AP_NONE: begin
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
         mpc_pkg::AP_PRIV_RW: begin
            rd_ok = priv;
            wr_ok = priv;
         end
         mpc_pkg::AP_USER_RO: begin
            rd_ok = 1'b1;
            wr_ok = priv;
         end
         mpc_pkg::AP_FULL: begin
            rd_ok = 1'b1;
            wr_ok = 1'b1;
         end
         mpc_pkg::AP_PRIV_RO: begin
            rd_ok = priv;
            wr_ok = 1'b0;
         end
         mpc_pkg::AP_RO_A, mpc_pkg::AP_RO_B: begin
            rd_ok = 1'b1;
            wr_ok = 1'b0;
         end
         default: begin
            // Unpredictable code, safest answer is deny
            rd_ok = 1'b0;
            wr_ok = 1'b0;
         end
      endcase
      if (fetch) begin
         allowed = rd_ok && !xn;
      end else if (write) begin
         allowed = wr_ok;
      end else begin
         allowed = rd_ok;
      end
   end

endmodule

//--- mpc_checker_asserts.sv
/*
 * Port-level assertions for the region attribute and permission checker.
 * Bound to every mpc_checker instance; sees only that module's ports.
 */
`timescale 1ns/1ps
module mpc_checker_asserts #(
   parameter int NREG = 8                      // number of regions
) (
   input wire logic                 CLK,       // core clock
   input wire logic                 RSTN,      // async reset, active low
   input wire logic [7:0]           REG_ADDR,  // register address
   input wire logic [31:0]          REG_WDATA, // register write data
   input wire logic                 REG_WR,    // write strobe
   input wire logic                 REG_RD,    // read strobe
   input wire logic [31:0]          REG_RDATA, // read data
   input wire mpc_pkg::mpc_access_s ACC,       // access request
   input wire logic                 ACC_DONE,  // verdict pulse
   input wire logic                 ACC_FAULT, // denied pulse
   input wire mpc_pkg::mpc_mem_attr_s ACC_ATTR, // decoded attributes
   input wire logic                 MM_FAULT   // exception request
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   AST_DONE_LAT: assert property (ACC.valid |=> ACC_DONE)
      else $error("verdict missing one cycle after request");
   AST_DONE_ONLY: assert property (!ACC.valid |=> !ACC_DONE && !ACC_FAULT)
      else $error("verdict without request");
   AST_EXC_SAME: assert property (ACC_FAULT |-> MM_FAULT ##1 !MM_FAULT || ACC_FAULT)
      else $error("exception request does not follow fault");
   AST_EXC_CAUSE: assert property (MM_FAULT |-> ACC_FAULT && ACC_DONE)
      else $error("exception request without denied access");
   AST_ATTR_HOLD: assert property (!ACC.valid |=> $stable(ACC_ATTR))
      else $error("attributes moved without request");
   AST_RD_IDLE: assert property (!REG_RD |=> REG_RDATA == 32'h0)
      else $error("read data outside answer cycle");
   AST_SHARE_IGN: assert property (ACC_DONE && ACC_ATTR.mtype == mpc_pkg::MEM_STRONG
      |-> ACC_ATTR.shareable)
      else $error("strongly ordered memory not shareable");
   AST_RESV_DEF: assert property (ACC_ATTR.reserved |->
      ACC_ATTR.mtype == mpc_pkg::MEM_STRONG && ACC_ATTR.inner == 2'h0 && ACC_ATTR.outer == 2'h0)
      else $error("reserved encoding not at default");

   cover property (ACC_FAULT);
   cover property (ACC_DONE && ACC_ATTR.reserved);
   cover property (REG_RD ##1 REG_RDATA != 32'h0);
endmodule

bind mpc_checker mpc_checker_asserts #(.NREG(NREG)) u_mpc_checker_asserts (
   .CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ACC(ACC),
   .ACC_DONE(ACC_DONE), .ACC_FAULT(ACC_FAULT), .ACC_ATTR(ACC_ATTR), .MM_FAULT(MM_FAULT));

//--- mpc_core_model.sv
/*
 * Behavioural core issuing one access at a time on the access port.
 * Called by the bench; request lasts one cycle, then the lines are released.
 */
`timescale 1ns/1ps
module mpc_core_model (
   input  wire logic            clk,  // core clock
   output mpc_pkg::mpc_access_s acc   // access request
);
   initial acc = '0;

   task automatic go(input logic [31:0] a, input logic w, input logic p, input logic f);
      @(posedge clk);
      acc <= '{1'b1, a, w, p, f};
      @(posedge clk);
      // Released lines inverted so a stale address never looks valid
      acc <= '{1'b0, ~a, ~w, ~p, ~f};
   endtask
endmodule

//--- testbench.sv
/*
 * Self-checking bench of the region attribute and permission checker.
 * Registers via the plain port; accesses through the core model.
 */
`timescale 1ns/1ps
module testbench;
   logic                   clk = 1'b0;
   logic                   rstn;
   logic [7:0]             reg_addr;
   logic [31:0]            reg_wdata;
   logic                   reg_wr;
   logic                   reg_rd;
   logic [31:0]            reg_rdata;
   mpc_pkg::mpc_access_s   acc;
   logic                   acc_done;
   logic                   acc_fault;
   mpc_pkg::mpc_mem_attr_s acc_attr;
   logic                   mm_fault;
   int                     err_count;
   int                     n_tests;
   logic [23:0]            tbl [14];

   mpc_checker #(.NREG(8)) u_mpc_checker (
      .CLK(clk), .RSTN(rstn), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ACC(acc),
      .ACC_DONE(acc_done), .ACC_FAULT(acc_fault), .ACC_ATTR(acc_attr), .MM_FAULT(mm_fault));
   mpc_core_model u_mpc_core_model (.clk(clk), .acc(acc));

   always #20 clk = ~clk;

   function automatic logic [31:0] aw(input logic [2:0] ap, input logic [5:0] tscb,
      input logic xn, input logic [7:0] subregion_disable_field, input logic [4:0] sz);
      aw = {3'h0, xn, 1'b0, ap, 2'h0, tscb, subregion_disable_field, 2'h0, sz, 1'b1};
   endfunction

   function automatic logic pa(input logic [2:0] ap, input logic p, input logic w);
      case (ap)
         3'h1: pa = p;
         3'h2: pa = p | !w;
         3'h3: pa = 1'b1;
         3'h5: pa = p & !w;
         3'h6, 3'h7: pa = !w;
         default: pa = 1'b0;
      endcase
   endfunction

   task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chk_a(input logic [7:0] g, input logic [7:0] e, input logic [7:0] m);
      n_tests++;
      if ((g & m) !== (e & m)) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk_d(reg_rdata, e);
   endtask

   // Done and fault checked together in the answer cycle
   task automatic ac(input logic [31:0] a, input logic w, input logic p, input logic f,
      input logic ef);
      u_mpc_core_model.go(a, w, p, f);
      #1;
      chk_d({29'h0, acc_done, acc_fault, mm_fault}, {29'h0, 1'b1, ef, ef});
   endtask

   task automatic summarize;
      $display("comparisons=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #2000000;
      err_count++;
      summarize();
   end

   initial begin
      rstn = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      err_count = 0;
      n_tests = 0;
      // Code {tex,s,c,b}, expected {type,share,inner,outer,resv}, compare mask
      tbl = '{24'h04_20_E1, 24'h05_60_E1, 24'h02_94_FF, 24'h06_B4_FF, 24'h03_94_FF,
              24'h0C_A0_FF, 24'h0F_AA_FF, 24'h09_21_FF, 24'h14_40_E1, 24'h13_21_FF,
              24'h18_21_FF, 24'h35_AC_FF, 24'h3A_96_FF, 24'h23_98_FF};
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd(mpc_pkg::OFS_CTRL, 32'h0);
      rd(mpc_pkg::OFS_FSR, 32'h0);
      chk_a(acc_attr, 8'h94, 8'hFF);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0);
      ac(32'h0000_1000, 1'b1, 1'b0, 1'b0, 1'b0);
      wr(mpc_pkg::OFS_CTRL, 32'h1);
      wr(mpc_pkg::OFS_NUMBER, 32'h0);
      wr(mpc_pkg::OFS_BASE, 32'h0);
      for (int i = 0; i < 32; i++) begin
         wr(mpc_pkg::OFS_ATTR, aw(i[4:2], 6'h02, 1'b0, 8'h00, 5'h1F));
         ac(32'h2000_0100 + i * 4, i[1], i[0], 1'b0,
            !pa(i[4:2], i[0], i[1]));
      end
      wr(mpc_pkg::OFS_ATTR, aw(3'h3, 6'h02, 1'b1, 8'h00, 5'h1F));
      ac(32'h0000_2000, 1'b0, 1'b1, 1'b1, 1'b1);
      rd(mpc_pkg::OFS_FSR, 32'h83);
      rd(mpc_pkg::OFS_FADDR, 32'h2000_0100);
      wr(mpc_pkg::OFS_FSR, 32'h83);
      rd(mpc_pkg::OFS_FSR, 32'h0);
      for (int i = 0; i < 14; i++) begin
         wr(mpc_pkg::OFS_ATTR, aw(3'h3, tbl[i][21:16], 1'b0, 8'h00, 5'h1F));
         ac(32'h0000_4000, 1'b1, 1'b0, 1'b0, 1'b0);
         chk_a(acc_attr, tbl[i][15:8], tbl[i][7:0]);
      end
      wr(mpc_pkg::OFS_BASE, 32'h2000_0011);
      rd(mpc_pkg::OFS_BASE, 32'h2000_0001);
      wr(mpc_pkg::OFS_ATTR, aw(3'h0, 6'h02, 1'b0, 8'h00, 5'h04));
      rd(mpc_pkg::OFS_ATTR, aw(3'h0, 6'h02, 1'b0, 8'h00, 5'h04));
      ac(32'h2000_0010, 1'b0, 1'b1, 1'b0, 1'b1);
      ac(32'h2000_0020, 1'b0, 1'b1, 1'b0, 1'b0);
      wr(mpc_pkg::OFS_ATTR, aw(3'h3, 6'h02, 1'b0, 8'h01, 5'h07));
      ac(32'h2000_0000, 1'b1, 1'b0, 1'b0, 1'b0);
      wr(mpc_pkg::OFS_NUMBER, 32'h0);
      wr(mpc_pkg::OFS_ATTR, 32'h0);
      ac(32'h2000_0004, 1'b1, 1'b1, 1'b0, 1'b1);
      ac(32'h2000_0024, 1'b1, 1'b0, 1'b0, 1'b0);
      ac(32'h3000_0000, 1'b0, 1'b1, 1'b0, 1'b1);
      wr(mpc_pkg::OFS_CTRL, 32'h5);
      ac(32'h3000_0000, 1'b0, 1'b1, 1'b0, 1'b0);
      ac(32'h3000_0000, 1'b0, 1'b0, 1'b0, 1'b1);
      summarize();
   end
endmodule
